// ---- verilog/acc_pkg.sv ----
// constants, field positions and carrier types of the comparator control
package acc_pkg;

  // register byte offsets from the peripheral base
  localparam logic [31:0] ACC_BASE_ADDR = 32'h4003c000;
  localparam logic [7:0] OFS_MASKED_STATUS = 8'h00;
  localparam logic [7:0] OFS_RAW_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h08;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h0c;
  localparam logic [7:0] OFS_LADDER_CTRL = 8'h10;
  localparam logic [7:0] OFS_RESULT_STATUS = 8'h20;
  localparam logic [7:0] OFS_CONFIG = 8'h24;

  // interrupt status, enable and clear layout
  localparam int INT_EVENT_BIT = 0;

  // reference_ladder_control layout
  localparam int LADDER_POWER_BIT = 9;
  localparam int LADDER_RANGE_BIT = 8;
  localparam int LADDER_TAP_LSB = 0;
  localparam int LADDER_TAP_W = 4;

  // comparator_result_status layout
  localparam int STATUS_VALUE_BIT = 1;

  // comparator_config layout
  localparam int CFG_INVERT_BIT = 1;
  localparam int CFG_INT_SENSE_LSB = 2;
  localparam int CFG_INT_LEVEL_BIT = 4;
  localparam int CFG_TRIG_SENSE_LSB = 5;
  localparam int CFG_TRIG_LEVEL_BIT = 7;
  localparam int CFG_PIN_EN_BIT = 8;
  localparam int CFG_SRC_LSB = 9;
  localparam int CFG_TRIG_EN_BIT = 11;

  // noninverting source codes
  localparam logic [1:0] SRC_POS_PIN_A = 2'h0;
  localparam logic [1:0] SRC_POS_PIN_B = 2'h1;
  localparam logic [1:0] SRC_LADDER = 2'h2;

  // edge or level sense codes
  localparam logic [1:0] SENSE_LEVEL = 2'h0;
  localparam logic [1:0] SENSE_FALL = 2'h1;
  localparam logic [1:0] SENSE_RISE = 2'h2;
  localparam logic [1:0] SENSE_BOTH = 2'h3;

  // ladder geometry in resistor units
  localparam logic [5:0] LADDER_UNITS_LOW = 6'h20;
  localparam logic [5:0] LADDER_UNITS_HIGH = 6'h18;
  localparam logic [5:0] LADDER_TAP_OFFSET = 6'h08;

  // ahb transfer type bit that marks an active transfer
  localparam int HTRANS_ACTIVE_BIT = 1;

  typedef struct packed {
    logic power;
    logic range;
    logic [LADDER_TAP_W-1:0] tap;
  } acc_ladder_t;

  typedef struct packed {
    logic trig_en;
    logic [1:0] src;
    logic pin_en;
    logic trig_level;
    logic [1:0] trig_sense;
    logic int_level;
    logic [1:0] int_sense;
    logic invert;
  } acc_config_t;

  typedef struct packed {
    logic sel_pos_pin;
    logic sel_ladder;
    logic sel_neg_pin;
    logic ladder_power;
    logic ref_ground;
    logic [5:0] ladder_units;
    logic [5:0] tap_position;
  } acc_analog_t;

  localparam acc_ladder_t LADDER_RESET = '0;
  localparam acc_config_t CONFIG_RESET = '0;
  localparam logic INT_ENABLE_RESET = 1'b0;
  localparam logic RAW_STATUS_RESET = 1'b0;

endpackage : acc_pkg

// ---- verilog/acc_sense.sv ----
// edge or level matcher for one consumer of the comparator result
`timescale 1ns/10ps
module acc_sense
  import acc_pkg::*;
(
  // comparator value now and one cycle ago
  input wire logic cur,
  input wire logic prev,
  // selected sense and level
  input wire logic [1:0] sense,
  input wire logic level_val,
  // match
  output logic hit
);

  always_comb begin
    unique case (sense)
      SENSE_LEVEL: hit = (cur == level_val);
      SENSE_FALL: hit = prev & ~cur;
      SENSE_RISE: hit = ~prev & cur;
      SENSE_BOTH: hit = prev ^ cur;
    endcase
  end

endmodule : acc_sense

// ---- verilog/acc_top.sv ----
// comparator control: ahb-lite registers, reference ladder, events
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/10ps
// Overview of operation
// - interrupt and converter trigger each have their own sense logic.
// - the result can drive the pin, raise an interrupt or fire a trigger.
// - source 00 or 01 picks the positive pin, 10 the ladder, 11 none.
// - the inverting input connects to the negative pin, except while reset holds analog_ctrl cleared.
// - an unpowered ladder gives ground whatever tap and range hold.
// - powered with range clear, tap plus eight out of thirty-two units.
// - powered with range set, the tap itself out of twenty-four units.
// - the status register shows the registered comparator result after optional inversion.
// - writing 0x30c powers the ladder, range set, tap twelve.
// - writing 0x40c picks the ladder and leaves the pin undriven.
// - registers decode at base plus offset, ladder 0x10, config 0x24.
// - ladder register: power bit 9, range bit 8, tap bits 3:0.
module acc_top
  import acc_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = ACC_BASE_ADDR
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // comparator core
  input wire logic comparator_result,
  output acc_analog_t analog_ctrl,
  // output pin
  output logic comparator_output_pin,
  output logic comparator_output_pin_oe,
  // converter trigger and interrupt
  output logic adc_trigger,
  output logic irq
);

  acc_ladder_t ladder;
  acc_config_t config_r;
  acc_analog_t next_analog;
  logic int_enable;
  logic raw_status;
  logic output_value;
  logic prev_value;
  logic int_hit;
  logic trig_hit;
  logic int_clear;
  logic addr_taken;
  logic addr_hit;
  logic [7:0] addr_ofs;
  logic wr_pend;
  logic [7:0] wr_ofs;
  logic [31:0] next_rdata;

  // ------------------------------------------------------------
  // bus slave: zero wait states, always okay
  // ------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign addr_taken = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
  assign addr_ofs = haddr[7:0];
  assign addr_hit = (haddr[31:8] == BASE_ADDR[31:8]) &&
                    (haddr[1:0] == 2'h0);

  // write address phase is held for the data phase
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
    end else begin
      wr_pend <= addr_taken & hwrite & addr_hit;
      if (addr_taken) begin
        wr_ofs <= addr_ofs;
      end
    end
  end

  // read data mux, unmapped and reserved bits read zero
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (addr_ofs)
      OFS_MASKED_STATUS: begin
        next_rdata[INT_EVENT_BIT] = raw_status & int_enable;
      end
      OFS_RAW_STATUS: begin
        next_rdata[INT_EVENT_BIT] = raw_status;
      end
      OFS_INT_ENABLE: begin
        next_rdata[INT_EVENT_BIT] = int_enable;
      end
      OFS_LADDER_CTRL: begin
        next_rdata[LADDER_POWER_BIT] = ladder.power;
        next_rdata[LADDER_RANGE_BIT] = ladder.range;
        next_rdata[LADDER_TAP_LSB +: LADDER_TAP_W] = ladder.tap;
      end
      OFS_RESULT_STATUS: begin
        next_rdata[STATUS_VALUE_BIT] = output_value;
      end
      OFS_CONFIG: begin
        next_rdata[CFG_INVERT_BIT] = config_r.invert;
        next_rdata[CFG_INT_SENSE_LSB +: 2] = config_r.int_sense;
        next_rdata[CFG_INT_LEVEL_BIT] = config_r.int_level;
        next_rdata[CFG_TRIG_SENSE_LSB +: 2] = config_r.trig_sense;
        next_rdata[CFG_TRIG_LEVEL_BIT] = config_r.trig_level;
        next_rdata[CFG_PIN_EN_BIT] = config_r.pin_en;
        next_rdata[CFG_SRC_LSB +: 2] = config_r.src;
        next_rdata[CFG_TRIG_EN_BIT] = config_r.trig_en;
      end
      default: begin
        next_rdata = 32'h00000000;
      end
    endcase
  end

  // read data is caught at the address phase edge
  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addr_taken && !hwrite && addr_hit) begin
      hrdata <= next_rdata;
    end else if (addr_taken) begin
      hrdata <= 32'h00000000;
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  // reference ladder control
  always_ff @(posedge clk) begin
    if (rst) begin
      ladder <= LADDER_RESET;
    end else if (wr_pend && wr_ofs == OFS_LADDER_CTRL) begin
      ladder.power <= hwdata[LADDER_POWER_BIT];
      ladder.range <= hwdata[LADDER_RANGE_BIT];
      ladder.tap <= hwdata[LADDER_TAP_LSB +: LADDER_TAP_W];
    end
  end

  // comparator configuration
  always_ff @(posedge clk) begin
    if (rst) begin
      config_r <= CONFIG_RESET;
    end else if (wr_pend && wr_ofs == OFS_CONFIG) begin
      config_r.invert <= hwdata[CFG_INVERT_BIT];
      config_r.int_sense <= hwdata[CFG_INT_SENSE_LSB +: 2];
      config_r.int_level <= hwdata[CFG_INT_LEVEL_BIT];
      config_r.trig_sense <= hwdata[CFG_TRIG_SENSE_LSB +: 2];
      config_r.trig_level <= hwdata[CFG_TRIG_LEVEL_BIT];
      config_r.pin_en <= hwdata[CFG_PIN_EN_BIT];
      config_r.src <= hwdata[CFG_SRC_LSB +: 2];
      config_r.trig_en <= hwdata[CFG_TRIG_EN_BIT];
    end
  end

  // interrupt enable
  always_ff @(posedge clk) begin
    if (rst) begin
      int_enable <= INT_ENABLE_RESET;
    end else if (wr_pend && wr_ofs == OFS_INT_ENABLE) begin
      int_enable <= hwdata[INT_EVENT_BIT];
    end
  end

  // write-one-to-clear strobe
  assign int_clear = wr_pend && (wr_ofs == OFS_INT_CLEAR) &&
                     hwdata[INT_EVENT_BIT];

  // ------------------------------------------------------------
  // comparator result path
  // ------------------------------------------------------------
  // result with optional inversion, and its previous value
  always_ff @(posedge clk) begin
    if (rst) begin
      output_value <= 1'b0;
      prev_value <= 1'b0;
    end else begin
      output_value <= comparator_result ^ config_r.invert;
      prev_value <= output_value;
    end
  end

  // independent sense logic for interrupt and trigger
  acc_sense u_int_sense (
    .cur (output_value),
    .prev (prev_value),
    .sense (config_r.int_sense),
    .level_val (config_r.int_level),
    .hit (int_hit)
  );

  acc_sense u_trig_sense (
    .cur (output_value),
    .prev (prev_value),
    .sense (config_r.trig_sense),
    .level_val (config_r.trig_level),
    .hit (trig_hit)
  );

  // sticky event, a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      raw_status <= RAW_STATUS_RESET;
    end else if (int_hit) begin
      raw_status <= 1'b1;
    end else if (int_clear) begin
      raw_status <= 1'b0;
    end
  end

  // level interrupt from enabled status
  assign irq = raw_status & int_enable;

  // converter trigger
  always_ff @(posedge clk) begin
    if (rst) begin
      adc_trigger <= 1'b0;
    end else begin
      adc_trigger <= trig_hit & config_r.trig_en;
    end
  end

  // output pin follows the result while enabled
  assign comparator_output_pin = output_value;
  assign comparator_output_pin_oe = config_r.pin_en;

  // ------------------------------------------------------------
  // analog steering and reference ladder
  // ------------------------------------------------------------
  always_comb begin
    next_analog = '0;
    next_analog.sel_neg_pin = 1'b1;
    next_analog.sel_pos_pin = (config_r.src == SRC_POS_PIN_A) ||
                              (config_r.src == SRC_POS_PIN_B);
    next_analog.sel_ladder = (config_r.src == SRC_LADDER);
    next_analog.ladder_power = ladder.power;
    next_analog.ref_ground = ~ladder.power;
    if (!ladder.power) begin
      next_analog.ladder_units = LADDER_UNITS_HIGH;
      next_analog.tap_position = 6'h00;
    end else if (!ladder.range) begin
      next_analog.ladder_units = LADDER_UNITS_LOW;
      next_analog.tap_position = {2'h0, ladder.tap} + LADDER_TAP_OFFSET;
    end else begin
      next_analog.ladder_units = LADDER_UNITS_HIGH;
      next_analog.tap_position = {2'h0, ladder.tap};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl <= next_analog;
    end
  end

endmodule : acc_top

// ---- test/acc_top_sva.sv ----
// assertion checker on the comparator control ports
`timescale 1ns/10ps
module acc_top_sva
  import acc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  // comparator side
  input wire logic comparator_result,
  input wire acc_analog_t analog_ctrl,
  input wire logic comparator_output_pin,
  input wire logic comparator_output_pin_oe
);
  logic wr;
  assign wr = hsel && htrans[1] && hwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_NEG: assert property (!$past(rst) |-> analog_ctrl.sel_neg_pin)
    else $error("negative pin not selected");
  AST_GND: assert property (!$past(rst) && !analog_ctrl.ladder_power
    |-> analog_ctrl.ref_ground && analog_ctrl.tap_position == 6'h00)
    else $error("unpowered ladder not ground");
  AST_LOW: assert property (analog_ctrl.ladder_power
    && analog_ctrl.ladder_units != 6'h18 |-> analog_ctrl.ladder_units == 6'h20
    && analog_ctrl.tap_position >= 6'h08 && analog_ctrl.tap_position <= 6'h17)
    else $error("low range tap wrong");
  AST_HIGH: assert property (analog_ctrl.ladder_power
    && analog_ctrl.ladder_units == 6'h18 |-> analog_ctrl.tap_position <= 6'h0f)
    else $error("high range tap wrong");
  AST_SRC: assert property (!(analog_ctrl.sel_pos_pin
    && analog_ctrl.sel_ladder)) else $error("two sources selected");
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  AST_PIN: assert property (!$past(rst, 2)
    && $changed(comparator_output_pin) |-> $past(wr, 2) || $past(wr, 3)
    || $past(comparator_result) != $past(comparator_result, 2))
    else $error("pin changed without cause");
  AST_OE: assert property ($changed(comparator_output_pin_oe)
    |-> $past(wr, 2)) else $error("pin enable changed without write");
  AST_PWR: assert property ($changed(analog_ctrl.ladder_power)
    |-> $past(wr, 2) || $past(wr, 3)) else $error("power changed alone");
endmodule : acc_top_sva

// ---- test/acc_analog_model.sv ----
// behavioural model of the analog inputs and the comparator
`timescale 1ns/10ps
module acc_analog_model
  import acc_pkg::*;
#(
  parameter int AVDD_MV = 3300
)
(
  // reference selection from the block
  input wire acc_analog_t analog_ctrl,
  // pin voltages in millivolts
  input var int pos_mv,
  input var int neg_mv,
  // comparator decision
  output logic comparator_result
);
  int vref;
  int vplus;
  always_comb begin
    vref = 0;
    if (!analog_ctrl.ref_ground && analog_ctrl.ladder_units != 6'h00)
      vref = AVDD_MV * int'(analog_ctrl.tap_position)
        / int'(analog_ctrl.ladder_units);
    vplus = analog_ctrl.sel_pos_pin ? pos_mv
      : (analog_ctrl.sel_ladder ? vref : 0);
    comparator_result = analog_ctrl.sel_neg_pin && vplus > neg_mv;
  end
endmodule : acc_analog_model

// ---- test/analog_comparator_control_tb.sv ----
// self-checking bench for the comparator control block
`timescale 1ns/10ps
module analog_comparator_control_tb;
  import acc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, cmp, oe, pin, trig, irq;
  logic [31:0] hrdata, rv, d;
  acc_analog_t ana;
  int pos_mv = 0;
  int neg_mv = 0;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int trig_n = 0;
  int t0;
  int seed = 32'h51a86907;
  logic [7:0] ofs [5] = '{8'h00, 8'h08, 8'h10, 8'h20, 8'h24};
  always #5 clk = ~clk;
  assign hready = hreadyout;
  acc_top u_acc_top (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .comparator_result(cmp),
    .analog_ctrl(ana), .comparator_output_pin(pin),
    .comparator_output_pin_oe(oe), .adc_trigger(trig), .irq);
  acc_analog_model u_acc_analog_model (.analog_ctrl(ana), .pos_mv, .neg_mv,
    .comparator_result(cmp));
  always @(posedge clk) begin
    cyc++;
    if (trig === 1'b1)
      trig_n++;
    if (cyc == 4000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] o, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= ACC_BASE_ADDR | {24'h0, o};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] o, input logic [31:0] e);
    bus(1'b0, o, 32'h0);
    chk($sformatf("reg %h", o), e, rv);
  endtask : rd
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask : settle
  function automatic logic [31:0] exp_ana(input logic [31:0] l, c);
    acc_analog_t a;
    a = '0;
    a.sel_neg_pin = 1'b1;
    a.sel_pos_pin = c[10:9] < 2'h2;
    a.sel_ladder = c[10:9] == 2'h2;
    a.ladder_power = l[9];
    a.ref_ground = !l[9];
    a.ladder_units = (l[9] && !l[8]) ? 6'h20 : 6'h18;
    a.tap_position = l[9] ? {2'h0, l[3:0]} + (l[8] ? 6'h00 : 6'h08) : 6'h00;
    return 32'(a);
  endfunction : exp_ana
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0; // clock runs before first access
    @(posedge clk);
    foreach (ofs[i])
      rd(ofs[i], 32'h0);
    bus(1'b1, 8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    bus(1'b1, 8'h30, 32'hffffffff);
    rd(8'h30, 32'h0);
    bus(1'b1, 8'h10, 32'h100);
    settle();
    chk("quiet ground", exp_ana(32'h100, 0), 32'(ana));
    bus(1'b1, 8'h10, 32'h30c);
    bus(1'b1, 8'h24, 32'h40c);
    rd(8'h10, 32'h30c);
    rd(8'h24, 32'h40c);
    chk("mid ref", exp_ana(32'h30c, 32'h40c), 32'(ana));
    chk("pin oe", 0, oe);
    neg_mv <= 1000;
    settle();
    rd(8'h20, 32'h2);
    neg_mv <= 2000;
    settle();
    rd(8'h20, 32'h0);
    for (int i = 0; i < 16; i++) begin
      d = $random(seed);
      bus(1'b1, 8'h10, d);
      rd(8'h10, d & 32'h30f);
      chk("ladder", exp_ana(d, 32'h40c), 32'(ana));
    end
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, 8'h24, 32'($random(seed)) & 32'h9ff | 32'(s) << 9);
      rd(8'h24, (32'(s) << 9) | (hwdata & 32'h9fe));
      chk("source", exp_ana(d, 32'(s) << 9), 32'(ana));
    end
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h24, 32'h928);
    pos_mv <= 0;
    neg_mv <= 1000;
    settle();
    bus(1'b1, 8'h0c, 32'h1);
    rd(8'h04, 32'h0);
    t0 = trig_n;
    pos_mv <= 2000;
    settle();
    rd(8'h20, 32'h2);
    rd(8'h00, 32'h1);
    chk("irq", 1, irq);
    chk("pin", 1, pin);
    chk("oe", 1, oe);
    chk("trig rise", 0, trig_n - t0);
    pos_mv <= 0;
    settle();
    chk("trig fall", 1, trig_n - t0);
    bus(1'b1, 8'h0c, 32'h1);
    rd(8'h04, 32'h0);
    chk("irq clr", 0, irq);
    bus(1'b1, 8'h08, 32'h0);
    pos_mv <= 2000;
    settle();
    rd(8'h04, 32'h1);
    rd(8'h00, 32'h0);
    chk("irq mask", 0, irq);
    give_verdict();
  end
endmodule : analog_comparator_control_tb
bind acc_top acc_top_sva u_acc_top_sva (.clk, .rst, .hsel, .htrans, .hwrite,
  .hreadyout, .hresp, .comparator_result, .analog_ctrl, .comparator_output_pin,
  .comparator_output_pin_oe);
